// File: rtl/osc_tick_sync.sv
// Synchroniser and rising-edge tick for the low-speed oscillator input
`timescale 1ns/100ps
`default_nettype none
module osc_tick_sync
	import wake_timer_pkg::*;
(
	input  wire logic CLK,
	input  wire logic RST,
	input  wire logic osc_in,
	output var  logic tick
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
		logic tick;
	} sync_state_t;

	sync_state_t st_q;
	sync_state_t st_d;

	always_comb begin
		st_d      = st_q;
		st_d.meta = osc_in;
		st_d.sync = st_q.meta;
		st_d.last = st_q.sync;
		st_d.tick = st_q.sync & ~st_q.last;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tick = st_q.tick;

endmodule : osc_tick_sync
`default_nettype wire

// File: rtl/self_wakeup_timer.sv
// Self wake-up timer with prescaler, auto-reload counter and Wishbone slave
// ****************************************
// Functional notes
// ****************************************
// Functional notes
// RQ1: The timer keeps counting while the device is in Idle or Power-down.
// RQ2: The count clock comes only from the internal slow oscillator of about 10 kHz.
// RQ3: Software keeps the system clock at least twice the slow oscillator rate.
// RQ4: While running, the timer keeps its oscillator requested in Idle and Power-down.
// RQ5: Software enables the oscillator itself and waits for it to settle.
// RQ6: The core is an 8-bit auto-reload up-counter advanced by prescaled ticks.
// RQ7: The 3-bit prescale field picks 1/1,1/4,1/16,1/64,1/256,1/512,1/1024,1/2048.
// RQ8: Control bit 3 starts the timer when 1 and halts it when 0.
// RQ9: Rolling over from FFH sets the overflow flag and reloads the counter together.
// RQ10: The overflow flag at control bit 4 stays set until software clears it.
// RQ11: The flag raises an interrupt when timer and global interrupt enables are both 1.
// RQ12: Software writes the reload register only while the timer is halted.
// RQ13: Software avoids a reload of FFH with prescale 1/1.
// RQ14: The reload register is an 8-bit value readable and writable by software.
// RQ15: Starting the timer loads the counter from the reload value.
// RQ16: Oscillator ticks cross into the system clock domain without loss.
`timescale 1ns/100ps
`default_nettype none
module self_wakeup_timer
	import wake_timer_pkg::*;
#(
	parameter int ADR_W = 10
)(
	input  wire logic             CLK,
	input  wire logic             RST,
	input  wire logic             WB_CYC_I,
	input  wire logic             WB_STB_I,
	input  wire logic             WB_WE_I,
	input  wire logic [ADR_W-1:0] WB_ADR_I,
	input  wire logic [3:0]       WB_SEL_I,
	input  wire logic [31:0]      WB_DAT_I,
	output var  logic [31:0]      WB_DAT_O,
	output var  logic             WB_ACK_O,
	input  wire logic             LOW_OSC_IN,
	input  wire logic             IDLE_MODE,
	input  wire logic             POWER_DOWN,
	output var  logic             OSC_KEEP_ON,
	output var  logic             WAKE_EVENT,
	output var  logic             IRQ
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0]    reload;
		logic [7:0]    count;
		logic [10:0]   presc;
		prescale_sel_t ps_sel;
		logic          run;
		logic          flag;
		logic          irq_en;
		logic          gie;
		logic          ack;
		logic [31:0]   rdata;
		logic          keep_on;
		logic          wake;
		logic          irq;
	} timer_state_t;

	timer_state_t st_q;
	timer_state_t st_d;

	wb_req_t req;
	logic    osc_tick;

	// ****************************************
	// Oscillator tick crossing
	// ****************************************
	osc_tick_sync u_tick (          // [RQ2] [RQ16]
		.CLK    (CLK),
		.RST    (RST),
		.osc_in (LOW_OSC_IN),
		.tick   (osc_tick)
	);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [10:0] presc_last(input prescale_sel_t sel);
		case (sel)                                 // [RQ7]
			PS_DIV1:    presc_last = 11'h000;
			PS_DIV4:    presc_last = 11'h003;
			PS_DIV16:   presc_last = 11'h00F;
			PS_DIV64:   presc_last = 11'h03F;
			PS_DIV256:  presc_last = 11'h0FF;
			PS_DIV512:  presc_last = 11'h1FF;
			PS_DIV1024: presc_last = 11'h3FF;
			default:    presc_last = 11'h7FF;
		endcase
	endfunction : presc_last

	function automatic logic hit(input wb_req_t r, input logic [7:0] idx);
		hit = (r.idx == idx);
	endfunction : hit

	always_comb begin
		req     = '0;
		req.cyc = WB_CYC_I;
		req.stb = WB_STB_I;
		req.we  = WB_WE_I;
		req.sel = WB_SEL_I;
		req.idx = WB_ADR_I[9:2];
		req.dat = WB_DAT_I[7:0];
	end

	// ****************************************
	// Next state
	// ****************************************
	logic access;
	logic wr;
	logic step;
	logic ovf;
	logic start;
	logic flag_clr;

	always_comb begin
		st_d     = st_q;
		access   = req.cyc & req.stb & ~st_q.ack;
		wr       = access & req.we & req.sel[0];
		step     = 1'b0;
		ovf      = 1'b0;
		start    = 1'b0;
		flag_clr = 1'b0;

		// Bus handshake
		st_d.ack = access;
		st_d.rdata = '0;

		// Register writes
		if (wr && hit(req, IDX_WAKE_RELOAD_BYTE)) begin
			st_d.reload = req.dat;                         // [RQ14]
		end else if (wr && hit(req, IDX_WAKE_TIMER_CONTROL)) begin
			st_d.run    = req.dat[CTRL_RUN_BIT];           // [RQ8]
			st_d.ps_sel = prescale_sel_t'(req.dat[CTRL_PS_MSB:0]);
			start       = req.dat[CTRL_RUN_BIT] & ~st_q.run;
			flag_clr    = ~req.dat[CTRL_FLAG_BIT];         // [RQ10]
		end else if (wr && hit(req, IDX_WAKE_IRQ_STATUS)) begin
			flag_clr    = req.dat[STAT_FLAG_BIT];          // [RQ10]
		end else if (wr && hit(req, IDX_WAKE_IRQ_MASK)) begin
			st_d.irq_en = req.dat[MASK_ENABLE_BIT];
		end else if (wr && hit(req, IDX_GLOBAL_IRQ_CTRL)) begin
			st_d.gie    = req.dat[GIE_BIT];
		end

		// Register reads
		if (access && !req.we) begin
			if (hit(req, IDX_WAKE_RELOAD_BYTE)) begin
				st_d.rdata[7:0] = st_q.reload;                 // [RQ14]
			end else if (hit(req, IDX_WAKE_TIMER_CONTROL)) begin
				st_d.rdata[CTRL_FLAG_BIT]      = st_q.flag;
				st_d.rdata[CTRL_RUN_BIT]       = st_q.run;
				st_d.rdata[CTRL_PS_MSB:0]      = st_q.ps_sel;
			end else if (hit(req, IDX_WAKE_IRQ_STATUS)) begin
				st_d.rdata[STAT_FLAG_BIT]      = st_q.flag;
			end else if (hit(req, IDX_WAKE_IRQ_MASK)) begin
				st_d.rdata[MASK_ENABLE_BIT]    = st_q.irq_en;
			end else if (hit(req, IDX_GLOBAL_IRQ_CTRL)) begin
				st_d.rdata[GIE_BIT]            = st_q.gie;
			end else if (hit(req, IDX_WAKE_COUNT_VIEW)) begin
				st_d.rdata[7:0]                = st_q.count;
			end else begin
				st_d.rdata = '0;
			end
		end

		// Prescaler and counter, never gated by power mode
		if (start) begin
			st_d.count = st_q.reload;                      // [RQ15]
			st_d.presc = PRESC_ZERO;
		end else if (st_q.run && osc_tick) begin         // [RQ1] [RQ6]
			if (st_q.presc >= presc_last(st_q.ps_sel)) begin  // [RQ7]
				st_d.presc = PRESC_ZERO;
				step       = 1'b1;
			end else begin
				st_d.presc = st_q.presc + 11'h001;
			end
		end
		if (step) begin
			if (st_q.count == COUNT_TOP) begin
				ovf        = 1'b1;
				st_d.count = st_q.reload;                    // [RQ9]
			end else begin
				st_d.count = st_q.count + 8'h01;             // [RQ6]
			end
		end

		// Overflow flag: set wins over clear
		if (ovf) begin
			st_d.flag = 1'b1;                              // [RQ9] [RQ10]
		end else if (flag_clr) begin
			st_d.flag = 1'b0;
		end

		// Registered outputs
		st_d.wake    = ovf;
		st_d.irq     = st_d.flag & st_d.irq_en & st_d.gie;        // [RQ11]
		st_d.keep_on = st_d.run & (IDLE_MODE | POWER_DOWN);      // [RQ4]
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_q        <= '0;
			st_q.reload <= RELOAD_RESET;
			st_q.ps_sel <= prescale_sel_t'(PRESCALE_RESET);
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign WB_DAT_O    = st_q.rdata;
	assign WB_ACK_O    = st_q.ack;
	assign OSC_KEEP_ON = st_q.keep_on;
	assign WAKE_EVENT  = st_q.wake;
	assign IRQ         = st_q.irq;

endmodule : self_wakeup_timer
`default_nettype wire

// File: rtl/wake_timer_pkg.sv
// Package for the self wake-up timer: map, fields, reset values, prescale and request types
package wake_timer_pkg;

	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [7:0] IDX_WAKE_RELOAD_BYTE   = 8'h86;
	localparam logic [7:0] IDX_WAKE_TIMER_CONTROL = 8'h8F;
	localparam logic [7:0] IDX_WAKE_IRQ_STATUS    = 8'h90;
	localparam logic [7:0] IDX_WAKE_IRQ_MASK      = 8'h91;
	localparam logic [7:0] IDX_GLOBAL_IRQ_CTRL    = 8'h92;
	localparam logic [7:0] IDX_WAKE_COUNT_VIEW    = 8'h93;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_FLAG_BIT   = 4;
	localparam int CTRL_RUN_BIT    = 3;
	localparam int CTRL_PS_MSB     = 2;
	localparam int STAT_FLAG_BIT   = 0;
	localparam int MASK_ENABLE_BIT = 0;
	localparam int GIE_BIT         = 0;

	// ****************************************
	// Reset values and counts
	// ****************************************
	localparam logic [7:0]  RELOAD_RESET   = 8'h00;
	localparam logic [2:0]  PRESCALE_RESET = 3'h0;
	localparam logic [7:0]  COUNT_TOP      = 8'hFF;
	localparam logic [10:0] PRESC_ZERO     = 11'h000;
	localparam int          OSC_RATE_KHZ   = 10;

	// ****************************************
	// Prescale encodings
	// ****************************************
	typedef enum logic [2:0] {
		PS_DIV1, PS_DIV4, PS_DIV16, PS_DIV64,
		PS_DIV256, PS_DIV512, PS_DIV1024, PS_DIV2048
	} prescale_sel_t;

	// ****************************************
	// Wishbone request bundle
	// ****************************************
	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [3:0] sel;
		logic [7:0] idx;
		logic [7:0] dat;
	} wb_req_t;

endpackage : wake_timer_pkg

// File: tb/self_wakeup_timer_properties.sv
// Checker of the wake-up timer port behaviour
`timescale 1ns/100ps
`default_nettype none
module wake_timer_checker (
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	input wire logic        IDLE_MODE,
	input wire logic        POWER_DOWN,
	input wire logic        OSC_KEEP_ON,
	input wire logic        WAKE_EVENT,
	input wire logic        IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	wire logic wr = WB_CYC_I && WB_STB_I && WB_WE_I;
	wire logic lp = IDLE_MODE || POWER_DOWN;
	sequence req_s; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
	sequence ack_s; WB_ACK_O ##1 !WB_ACK_O; endsequence
	ack_answer_a: assert property (req_s |=> ack_s)
		else $error("ack not a single pulse");
	ack_idle_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
		else $error("ack without request");
	dat_zero_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
		else $error("read data outside ack");
	dat_upper_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
		else $error("upper read data set");
	keep_off_a: assert property (!lp |=> !OSC_KEEP_ON)
		else $error("osc kept on while awake");
	keep_hold_a: assert property (OSC_KEEP_ON && lp && !wr |=> OSC_KEEP_ON)
		else $error("osc released while sleeping");
	wake_pulse_a: assert property (WAKE_EVENT |=> !WAKE_EVENT)
		else $error("wake pulse too long");
	irq_hold_a: assert property (IRQ && !wr |=> IRQ)
		else $error("irq dropped without write");
	irq_cause_a: assert property ($rose(IRQ) && !$past(wr) |-> ##[0:2] WAKE_EVENT)
		else $error("irq without overflow");
endmodule : wake_timer_checker
bind self_wakeup_timer wake_timer_checker i_chk (.*);
`default_nettype wire

// File: tb/self_wakeup_timer_tb_top.sv
// Testbench of the wake-up timer
`timescale 1ns/100ps
`default_nettype none
module self_wakeup_timer_tb_top;
	import wake_timer_pkg::*;
	logic        clk, rst, cyc, stb, we, osc, idle, pd, ack, keep, wake, irq;
	logic [9:0]  adr;
	logic [31:0] wdat, rdat;
	int          miscompares = 0, compares = 0, wakes = 0, n;
	logic [7:0]  rl;
	self_wakeup_timer i_dut (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .LOW_OSC_IN(osc), .IDLE_MODE(idle), .POWER_DOWN(pd),
		.OSC_KEEP_ON(keep), .WAKE_EVENT(wake), .IRQ(irq));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (wake === 1'b1) wakes++;
	task automatic chk(input logic [31:0] a, input logic [31:0] e);
		compares++;
		if (a !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, a, e);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		input logic [7:0] e);
		int k;
		k = 0;
		@(posedge clk);
		{cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, idx, 2'b00, 24'h0, d};
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (k >= 50) begin
			miscompares++;
			complete_run();
		end
		if (!w) chk(rdat, {24'h0, e});
		{cyc, stb} <= 2'b00;
	endtask : wb
	task automatic pulse(input int c);
		repeat (c) begin
			repeat (4) @(posedge clk) osc <= 1;
			repeat (4) @(posedge clk) osc <= 0;
		end
	endtask : pulse
	task automatic complete_run;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	initial begin
		#1000000;
		miscompares++;
		complete_run();
	end
	initial begin
		{rst, cyc, stb, we, osc, idle, pd, adr, wdat} = {1'b1, 6'h0, 10'h0, 32'h0};
		repeat (10) @(posedge clk);
		rst <= 0;
		wb(0, IDX_WAKE_RELOAD_BYTE, 0, 0);
		wb(1, IDX_WAKE_RELOAD_BYTE, 8'hA5, 0);
		wb(0, IDX_WAKE_RELOAD_BYTE, 0, 8'hA5);
		wb(0, IDX_WAKE_TIMER_CONTROL, 0, 0);
		wb(0, 8'hFF, 0, 0);
		wb(1, IDX_WAKE_IRQ_MASK, 1, 0);
		wb(1, IDX_GLOBAL_IRQ_CTRL, 1, 0);
		{idle, pd} <= 2'b11;
		for (int ps = 0; ps < 8; ps++) begin
			n = (ps < 4) ? (1 << (2 * ps)) : (1 << (ps + 4));
			rl = (ps == 0) ? 8'hFE : 8'hFF;
			wb(1, IDX_WAKE_TIMER_CONTROL, 8'(ps), 0);
			wb(1, IDX_WAKE_RELOAD_BYTE, rl, 0);
			wb(1, IDX_WAKE_TIMER_CONTROL, 8'h08 | 8'(ps), 0);
			wb(0, IDX_WAKE_COUNT_VIEW, 0, rl);
			pulse((256 - int'(rl)) * n - 1);
			wb(0, IDX_WAKE_TIMER_CONTROL, 0, 8'h08 | 8'(ps));
			pulse(1);
			wb(0, IDX_WAKE_TIMER_CONTROL, 0, 8'h18 | 8'(ps));
			wb(0, IDX_WAKE_COUNT_VIEW, 0, rl);
			chk({30'h0, keep, irq}, 32'h3);
		end
		chk(32'(wakes), 32'h8);
		wb(1, IDX_WAKE_IRQ_MASK, 0, 0);
		chk({31'h0, irq}, 32'h0);
		wb(1, IDX_WAKE_IRQ_MASK, 1, 0);
		chk({31'h0, irq}, 32'h1);
		wb(1, IDX_WAKE_IRQ_STATUS, 1, 0);
		chk({31'h0, irq}, 32'h0);
		wb(0, IDX_WAKE_IRQ_STATUS, 0, 0);
		complete_run();
	end
endmodule : self_wakeup_timer_tb_top
`default_nettype wire
